//--- rtl/tmc_mode_clock_ctrl.sv
// Timer mode, clock select, capture control and force strobe logic
//
// Functional notes
// - Mode is control A low bits plus control B bits.
// - Fixed tops 0x00FF, 0x01FF, 0x03FF for modes 1-3, 5-7.
// - CTC top from compare A or capture; immediate update.
// - PWM buffer update and overflow point follow mode.
// - Variable-top modes; mode 0 to 0xFFFF; 13 reserved.
// - Filter needs four equal capture samples.
// - Edge select bit picks falling or rising capture.
// - Capture copies counter and sets capture flag.
// - Capture pin ignored while capture register is top.
// - Clock select zero stops the timer.
// - Codes 1-5 give divide 1, 8, 64, 256, 1024.
// - Codes 6, 7 count external falling, rising edges.
// - Control C holds force strobes at bits 7, 6.
// - Force only in non-PWM modes, reads zero, no side effects.
`timescale 1ns/100ps
module tmc_mode_clock_ctrl (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_we,
  output logic [7:0] cpu_rdata,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] compare_a_reg,
  input wire logic [15:0] capture_value_reg,
  input wire logic counter_at_top,
  input wire logic counter_at_bottom,
  input wire logic counter_at_max,
  input wire logic capture_pin,
  input wire logic ext_clock_pin,
  output logic [3:0] wave_mode,
  output logic [1:0] com_a,
  output logic [1:0] com_b,
  output logic [15:0] top_value,
  output tmc_pkg::tmc_point_e update_point,
  output logic count_tick,
  output logic overflow_flag_set,
  output logic capture_flag,
  output logic capture_load,
  output logic [15:0] capture_data,
  output logic force_compare_a,
  output logic force_compare_b
);
  import tmc_pkg::*;

  // ==========================================================================
  // Control registers
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic [3:0] mode;
  logic [2:0] clock_select_field;
  logic capture_noise_filter_en;
  logic capture_edge_select;

  assign wr_a = cpu_we && (cpu_addr == TMC_CTRL_A_ADDR);
  assign wr_b = cpu_we && (cpu_addr == TMC_CTRL_B_ADDR);
  assign wr_c = cpu_we && (cpu_addr == TMC_CTRL_C_ADDR);

  // Unused bits are masked at the write so they can never store
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_q <= TMC_CTRL_RESET;
      ctrl_b_q <= TMC_CTRL_RESET;
    end else begin
      if (wr_a) begin
        ctrl_a_q <= cpu_wdata & TMC_CTRL_A_MASK;
      end
      if (wr_b) begin
        ctrl_b_q <= cpu_wdata & TMC_CTRL_B_MASK;
      end
    end
  end

  assign mode = {ctrl_b_q[TMC_WGM_HI_MSB:TMC_WGM_HI_LSB], ctrl_a_q[TMC_WGM_LO_MSB:0]};
  assign clock_select_field = ctrl_b_q[TMC_CS_MSB:0];
  assign capture_noise_filter_en = ctrl_b_q[TMC_NOISE_BIT];
  assign capture_edge_select = ctrl_b_q[TMC_EDGE_BIT];
  assign wave_mode = mode;
  assign com_a = ctrl_a_q[TMC_COM_A_MSB:TMC_COM_A_LSB];
  assign com_b = ctrl_a_q[TMC_COM_B_MSB:TMC_COM_B_LSB];

  // ==========================================================================
  // Read path
  logic [7:0] rdata_mux;

  // Force strobes are never stored, so control C always reads zero
  assign rdata_mux = (cpu_addr == TMC_CTRL_A_ADDR) ? ctrl_a_q :
                     (cpu_addr == TMC_CTRL_B_ADDR) ? ctrl_b_q :
                     (cpu_addr == TMC_CTRL_C_ADDR) ? TMC_CTRL_C_READ :
                     8'h00;
  assign cpu_rdata = rdata_mux;

  // ==========================================================================
  // Top source, update point and overflow point
  tmc_top_src_e top_src;
  logic [15:0] top_d;
  tmc_point_e upd_d;
  logic is_fast;
  logic is_pc;
  logic is_nonpwm;
  logic icr_is_top;
  logic ovf_d;

  assign top_src = tmc_top_src_f(mode);
  assign is_fast = tmc_is_fast_f(mode);
  assign is_pc = tmc_is_pc_f(mode);
  assign is_nonpwm = tmc_is_nonpwm_f(mode);
  assign icr_is_top = (top_src == TMC_TOP_ICR);

  // Fixed tops and mode 0 come from the decode table; mode 13 falls back to MAX
  assign top_d = (top_src == TMC_TOP_CMPA) ? compare_a_reg :
                 (top_src == TMC_TOP_ICR) ? capture_value_reg :
                 tmc_fixed_top_f(mode);

  // Phase correct buffers at TOP, fast and phase-frequency correct at BOTTOM
  assign upd_d = is_nonpwm ? TMC_PT_IMM :
                 (mode == TMC_MODE_RESV) ? TMC_PT_IMM :
                 is_pc ? TMC_PT_TOP : TMC_PT_BOTTOM;

  // Reserved mode raises no overflow at all
  assign ovf_d = is_nonpwm ? counter_at_max :
                 (mode == TMC_MODE_RESV) ? 1'b0 :
                 is_fast ? counter_at_top : counter_at_bottom;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      top_value <= TMC_TOP_MAX;
      update_point <= TMC_PT_IMM;
      overflow_flag_set <= 1'b0;
    end else begin
      top_value <= top_d;
      update_point <= upd_d;
      overflow_flag_set <= ovf_d;
    end
  end

  // ==========================================================================
  // Prescaler and clock select
  logic [TMC_PRESC_W-1:0] presc_q;
  logic ext_sync1_q;
  logic ext_sync2_q;
  logic ext_prev_q;
  logic ext_rise;
  logic ext_fall;
  logic tick_d;

  // Shared free-running prescaler; a tap fires when its low bits are all ones
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      presc_q <= '0;
      ext_sync1_q <= 1'b0;
      ext_sync2_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 1'b1;
      ext_sync1_q <= ext_clock_pin;
      ext_sync2_q <= ext_sync1_q;
      ext_prev_q <= ext_sync2_q;
    end
  end

  assign ext_rise = ext_sync2_q & ~ext_prev_q;
  assign ext_fall = ~ext_sync2_q & ext_prev_q;

  always_comb begin
    case (clock_select_field)
      TMC_CS_STOP: tick_d = 1'b0;
      TMC_CS_DIV1: tick_d = 1'b1;
      TMC_CS_DIV8: tick_d = ((presc_q & TMC_TAP_DIV8) == TMC_TAP_DIV8);
      TMC_CS_DIV64: tick_d = ((presc_q & TMC_TAP_DIV64) == TMC_TAP_DIV64);
      TMC_CS_DIV256: tick_d = ((presc_q & TMC_TAP_DIV256) == TMC_TAP_DIV256);
      TMC_CS_DIV1024: tick_d = (presc_q == TMC_TAP_DIV1024);
      TMC_CS_EXT_FALL: tick_d = ext_fall;
      TMC_CS_EXT_RISE: tick_d = ext_rise;
      default: tick_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_tick <= 1'b0;
    end else begin
      count_tick <= tick_d;
    end
  end

  // ==========================================================================
  // Input capture
  logic capture_event;
  logic flag_d;

  tmc_capture_cond #(
    .SAMPLES(TMC_FILTER_SAMPLES)
  ) u_capture_cond (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .capture_pin(capture_pin),
    .filter_en(capture_noise_filter_en),
    .edge_rise(capture_edge_select),
    .capture_en(!icr_is_top),
    .capture_event(capture_event)
  );

  // With the capture register as top, the flag marks TOP instead of a capture
  assign flag_d = capture_event | (icr_is_top & counter_at_top);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      capture_load <= 1'b0;
      capture_data <= '0;
      capture_flag <= 1'b0;
    end else begin
      capture_load <= capture_event && !icr_is_top;
      capture_flag <= flag_d;
      if (capture_event) begin
        capture_data <= counter_value;
      end
    end
  end

  // ==========================================================================
  // Force compare strobes
  logic force_a_d;
  logic force_b_d;

  // Strobes leave no state behind: no counter clear, no flag, nothing to read back
  assign force_a_d = wr_c && cpu_wdata[TMC_FORCE_A_BIT] && is_nonpwm;
  assign force_b_d = wr_c && cpu_wdata[TMC_FORCE_B_BIT] && is_nonpwm;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      force_compare_a <= 1'b0;
      force_compare_b <= 1'b0;
    end else begin
      force_compare_a <= force_a_d;
      force_compare_b <= force_b_d;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_stop_no_tick: assert property (
    clock_select_field == TMC_CS_STOP ##1 clock_select_field == TMC_CS_STOP |-> !count_tick)
    else $error("tick while clock stopped");

  a_div8_spacing: assert property (
    (clock_select_field == TMC_CS_DIV8) [*8] ##1 (clock_select_field == TMC_CS_DIV8) ##1 count_tick |->
      $past(count_tick, 8))
    else $error("divide by eight spacing wrong");

  a_fixed_top: assert property (
    $stable(mode) && (mode == TMC_MODE_FAST9 || mode == TMC_MODE_PC9) |=> top_value == TMC_TOP_9BIT)
    else $error("nine bit top wrong");

  a_ctc_top: assert property (
    mode == TMC_MODE_CTC_A |=> top_value == $past(compare_a_reg) && update_point == TMC_PT_IMM)
    else $error("CTC top not from compare A");

  a_ovf_fast_top: assert property (
    is_fast && counter_at_top |=> overflow_flag_set)
    else $error("fast mode overflow missed at top");

  a_pc_update_top: assert property (
    is_pc |=> update_point == TMC_PT_TOP)
    else $error("phase correct update point wrong");

  a_capture_blocked: assert property (
    icr_is_top [*3] |-> !capture_load)
    else $error("capture while capture register is top");

  a_capture_copies: assert property (
    capture_load |-> capture_flag && capture_data == $past(counter_value))
    else $error("capture data or flag wrong");

  a_force_pwm_block: assert property (
    wr_c && !is_nonpwm |=> !force_compare_a && !force_compare_b)
    else $error("force strobe in PWM mode");

  a_ctrl_c_zero: assert property (
    cpu_addr == TMC_CTRL_C_ADDR |-> cpu_rdata == 8'h00)
    else $error("control C read not zero");

  a_ovf_pc_bottom: assert property (
    is_pc && counter_at_bottom |=> overflow_flag_set)
    else $error("phase correct overflow missed at bottom");

  a_ovf_ctc_max: assert property (
    is_nonpwm && counter_at_max |=> overflow_flag_set)
    else $error("non-PWM overflow missed at max");

  a_resv_no_ovf: assert property (
    mode == TMC_MODE_RESV |=> !overflow_flag_set)
    else $error("overflow raised in reserved mode");

  a_div1_tick: assert property (
    clock_select_field == TMC_CS_DIV1 |=> count_tick)
    else $error("undivided clock missed a tick");

  a_force_a_strobe: assert property (
    wr_c && is_nonpwm && cpu_wdata[TMC_FORCE_A_BIT] |=> force_compare_a)
    else $error("force strobe A missing");

endmodule : tmc_mode_clock_ctrl

//--- rtl/tmc_pkg.sv
// Package for the timer mode, clock select and capture control block
package tmc_pkg;

  // ==========================================================================
  // Register map and field layout
  localparam logic [7:0] TMC_CTRL_A_ADDR = 8'h90;
  localparam logic [7:0] TMC_CTRL_B_ADDR = 8'h91;
  localparam logic [7:0] TMC_CTRL_C_ADDR = 8'h92;
  localparam logic [7:0] TMC_CTRL_RESET = 8'h00;
  // Implemented bits of each register; all others read zero
  localparam logic [7:0] TMC_CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] TMC_CTRL_B_MASK = 8'hDF;
  localparam logic [7:0] TMC_CTRL_C_READ = 8'h00;
  localparam int TMC_COM_A_MSB = 7;
  localparam int TMC_COM_A_LSB = 6;
  localparam int TMC_COM_B_MSB = 5;
  localparam int TMC_COM_B_LSB = 4;
  localparam int TMC_WGM_LO_MSB = 1;
  localparam int TMC_NOISE_BIT = 7;
  localparam int TMC_EDGE_BIT = 6;
  localparam int TMC_WGM_HI_MSB = 4;
  localparam int TMC_WGM_HI_LSB = 3;
  localparam int TMC_CS_MSB = 2;
  localparam int TMC_FORCE_A_BIT = 7;
  localparam int TMC_FORCE_B_BIT = 6;

  // ==========================================================================
  // Waveform modes and fixed top values
  localparam logic [3:0] TMC_MODE_NORMAL = 4'h0;
  localparam logic [3:0] TMC_MODE_PC8 = 4'h1;
  localparam logic [3:0] TMC_MODE_PC9 = 4'h2;
  localparam logic [3:0] TMC_MODE_PC10 = 4'h3;
  localparam logic [3:0] TMC_MODE_CTC_A = 4'h4;
  localparam logic [3:0] TMC_MODE_FAST8 = 4'h5;
  localparam logic [3:0] TMC_MODE_FAST9 = 4'h6;
  localparam logic [3:0] TMC_MODE_FAST10 = 4'h7;
  localparam logic [3:0] TMC_MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] TMC_MODE_PFC_A = 4'h9;
  localparam logic [3:0] TMC_MODE_PC_CAP = 4'hA;
  localparam logic [3:0] TMC_MODE_PC_A = 4'hB;
  localparam logic [3:0] TMC_MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] TMC_MODE_RESV = 4'hD;
  localparam logic [3:0] TMC_MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] TMC_MODE_FAST_A = 4'hF;
  localparam logic [15:0] TMC_TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TMC_TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TMC_TOP_10BIT = 16'h03FF;
  localparam logic [15:0] TMC_TOP_MAX = 16'hFFFF;

  // ==========================================================================
  // Clock select codes and prescaler taps
  localparam logic [2:0] TMC_CS_STOP = 3'h0;
  localparam logic [2:0] TMC_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMC_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMC_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMC_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMC_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMC_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMC_CS_EXT_RISE = 3'h7;
  localparam int TMC_PRESC_W = 10;
  localparam logic [9:0] TMC_TAP_DIV8 = 10'h007;
  localparam logic [9:0] TMC_TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TMC_TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TMC_TAP_DIV1024 = 10'h3FF;
  localparam int TMC_FILTER_SAMPLES = 4;

  // ==========================================================================
  // Mode decode
  typedef enum logic [2:0] {TMC_TOP_FIXED = 3'b001, TMC_TOP_CMPA = 3'b010, TMC_TOP_ICR = 3'b100} tmc_top_src_e;
  typedef enum logic [2:0] {TMC_PT_IMM = 3'b001, TMC_PT_TOP = 3'b010, TMC_PT_BOTTOM = 3'b100} tmc_point_e;

  function automatic tmc_top_src_e tmc_top_src_f(input logic [3:0] mode);
    case (mode)
      TMC_MODE_CTC_A, TMC_MODE_PFC_A, TMC_MODE_PC_A, TMC_MODE_FAST_A: tmc_top_src_f = TMC_TOP_CMPA;
      TMC_MODE_PFC_CAP, TMC_MODE_PC_CAP, TMC_MODE_CTC_CAP, TMC_MODE_FAST_CAP: tmc_top_src_f = TMC_TOP_ICR;
      default: tmc_top_src_f = TMC_TOP_FIXED;
    endcase
  endfunction : tmc_top_src_f

  function automatic logic [15:0] tmc_fixed_top_f(input logic [3:0] mode);
    case (mode)
      TMC_MODE_PC8, TMC_MODE_FAST8: tmc_fixed_top_f = TMC_TOP_8BIT;
      TMC_MODE_PC9, TMC_MODE_FAST9: tmc_fixed_top_f = TMC_TOP_9BIT;
      TMC_MODE_PC10, TMC_MODE_FAST10: tmc_fixed_top_f = TMC_TOP_10BIT;
      default: tmc_fixed_top_f = TMC_TOP_MAX;
    endcase
  endfunction : tmc_fixed_top_f

  function automatic logic tmc_is_fast_f(input logic [3:0] mode);
    tmc_is_fast_f = (mode == TMC_MODE_FAST8) || (mode == TMC_MODE_FAST9) || (mode == TMC_MODE_FAST10) ||
                    (mode == TMC_MODE_FAST_CAP) || (mode == TMC_MODE_FAST_A);
  endfunction : tmc_is_fast_f

  function automatic logic tmc_is_pc_f(input logic [3:0] mode);
    tmc_is_pc_f = (mode == TMC_MODE_PC8) || (mode == TMC_MODE_PC9) || (mode == TMC_MODE_PC10) ||
                  (mode == TMC_MODE_PC_CAP) || (mode == TMC_MODE_PC_A);
  endfunction : tmc_is_pc_f

  function automatic logic tmc_is_nonpwm_f(input logic [3:0] mode);
    tmc_is_nonpwm_f = (mode == TMC_MODE_NORMAL) || (mode == TMC_MODE_CTC_A) || (mode == TMC_MODE_CTC_CAP);
  endfunction : tmc_is_nonpwm_f

endpackage : tmc_pkg

//--- rtl/tmc_capture_cond.sv
// Capture pin synchroniser, noise filter and edge selector
`timescale 1ns/100ps
module tmc_capture_cond #(
  parameter int SAMPLES = tmc_pkg::TMC_FILTER_SAMPLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic capture_pin,
  input wire logic filter_en,
  input wire logic edge_rise,
  input wire logic capture_en,
  output logic capture_event
);
  import tmc_pkg::*;

  // ==========================================================================
  // Synchroniser and filter
  logic sync1_q;
  logic sync2_q;
  logic [SAMPLES-2:0] hist_q;
  logic [SAMPLES-1:0] window;
  logic filt_q;
  logic filt_d;
  logic level;
  logic prev_q;
  logic rise;
  logic fall;
  logic event_d;
  logic all_high;
  logic all_low;

  // The current sample is the newest of the window, so the filter adds exactly SAMPLES cycles
  assign window = {hist_q, sync2_q};
  assign all_high = &window;
  assign all_low = ~|window;
  // Output only moves once the last samples all agree
  assign filt_d = all_high ? 1'b1 : (all_low ? 1'b0 : filt_q);
  assign level = filter_en ? filt_q : sync2_q;
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
  // Edge tracking continues while disabled so re-enabling makes no false edge
  assign event_d = capture_en & (edge_rise ? rise : fall);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      hist_q <= '0;
      filt_q <= 1'b0;
      prev_q <= 1'b0;
      capture_event <= 1'b0;
    end else begin
      sync1_q <= capture_pin;
      sync2_q <= sync1_q;
      hist_q <= {hist_q[SAMPLES-3:0], sync2_q};
      filt_q <= filt_d;
      prev_q <= level;
      capture_event <= event_d;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_settled_high;
    sync2_q [*4];
  endsequence

  a_filter_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_settled_high |=> filt_q)
    else $error("filter did not follow four equal samples");

  a_edge_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
    capture_event |-> $past(edge_rise) ? $past(rise) : $past(fall))
    else $error("capture on wrong edge");

endmodule : tmc_capture_cond

//--- bench/testbench.sv
// Self-checking testbench for the timer mode, clock select and capture control block
`timescale 1ns/100ps
module testbench;
  import tmc_pkg::*;

  // ==========================================================================
  // Stimulus and observed signals
  logic clk_sys;
  logic reset_n;
  logic [7:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_we;
  logic [7:0] cpu_rdata;
  logic [15:0] counter_value = 16'h0000;
  logic [15:0] compare_a_reg;
  logic [15:0] capture_value_reg;
  logic counter_at_top;
  logic counter_at_bottom;
  logic counter_at_max;
  logic capture_pin;
  logic ext_clock_pin;
  logic [3:0] wave_mode;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [15:0] top_value;
  tmc_point_e update_point;
  logic count_tick;
  logic overflow_flag_set;
  logic capture_flag;
  logic capture_load;
  logic [15:0] capture_data;
  logic force_compare_a;
  logic force_compare_b;
  int fail_count;
  int n_checks;
  logic [7:0] d;

  tmc_mode_clock_ctrl dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_we(cpu_we),
    .cpu_rdata(cpu_rdata), .counter_value(counter_value), .compare_a_reg(compare_a_reg),
    .capture_value_reg(capture_value_reg), .counter_at_top(counter_at_top), .counter_at_bottom(counter_at_bottom),
    .counter_at_max(counter_at_max), .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin),
    .wave_mode(wave_mode), .com_a(com_a), .com_b(com_b), .top_value(top_value), .update_point(update_point),
    .count_tick(count_tick), .overflow_flag_set(overflow_flag_set), .capture_flag(capture_flag),
    .capture_load(capture_load), .capture_data(capture_data), .force_compare_a(force_compare_a),
    .force_compare_b(force_compare_b)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Free-running counter so that captured samples are distinguishable
  always @(posedge clk_sys) begin
    counter_value <= counter_value + 16'h0001;
  end

  // ==========================================================================
  // Access tasks and expectations
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    cpu_we <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= v;
    @(posedge clk_sys);
    cpu_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    cpu_addr <= a;
    #1;
    v = cpu_rdata;
  endtask : rd

  function automatic logic [15:0] exp_top(input int m);
    case (m)
      1, 5: return TMC_TOP_8BIT;
      2, 6: return TMC_TOP_9BIT;
      3, 7: return TMC_TOP_10BIT;
      4, 9, 11, 15: return 16'h1000 + 16'(m);
      8, 10, 12, 14: return 16'h2000 + 16'(m);
      default: return TMC_TOP_MAX;
    endcase
  endfunction : exp_top

  function automatic tmc_point_e exp_pt(input int m);
    case (m)
      0, 4, 12, 13: return TMC_PT_IMM;
      1, 2, 3, 10, 11: return TMC_PT_TOP;
      default: return TMC_PT_BOTTOM;
    endcase
  endfunction : exp_pt

  // Which counter state sets overflow: 0 top, 1 bottom, 2 max, 3 none
  function automatic int ovf_src(input int m);
    case (m)
      0, 4, 12: return 2;
      5, 6, 7, 14, 15: return 0;
      13: return 3;
      default: return 1;
    endcase
  endfunction : ovf_src

  // Window of 2048 cycles is a whole number of every prescaler period
  task automatic cs_run(input logic [2:0] cs, input int exp);
    int cnt;
    cnt = 0;
    @(posedge clk_sys);
    ext_clock_pin <= 1'b0;
    wr(TMC_CTRL_B_ADDR, {5'b00000, cs});
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 2048; i++) begin
      @(posedge clk_sys);
      if (cs[2:1] == 2'b11 && i < 56 && i % 8 == 0) ext_clock_pin <= ~ext_clock_pin;
      #1;
      if (count_tick === 1'b1) cnt++;
    end
    check(16'(cnt), 16'(exp));
  endtask : cs_run

  // Pin first moves to the unselected level, then to the trigger level for width cycles
  task automatic cap_try(input logic [7:0] b, input logic trig_rise, input int width, input int exp_lat);
    int lat;
    lat = 0;
    wr(TMC_CTRL_B_ADDR, b);
    @(posedge clk_sys);
    capture_pin <= ~trig_rise;
    repeat (15) @(posedge clk_sys);
    capture_pin <= trig_rise;
    for (int i = 1; i <= 15; i++) begin
      @(posedge clk_sys);
      if (i == width) capture_pin <= ~trig_rise;
      #1;
      if (capture_load === 1'b1 && lat == 0) begin
        lat = i;
        check(16'(capture_flag), 16'h0001);
        check(capture_data, counter_value - 16'h0001);
      end
    end
    check(16'(lat), 16'(exp_lat));
  endtask : cap_try

  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    fail_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    cpu_we = 1'b0;
    compare_a_reg = 16'h0000;
    capture_value_reg = 16'h0000;
    {counter_at_top, counter_at_bottom, counter_at_max} = 3'b000;
    capture_pin = 1'b1;
    ext_clock_pin = 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    check(top_value, TMC_TOP_MAX);
    check(16'(update_point), 16'(TMC_PT_IMM));
    check(16'(wave_mode), 16'h0000);
    rd(TMC_CTRL_A_ADDR, d);
    check(16'(d), 16'(TMC_CTRL_RESET));
    rd(TMC_CTRL_B_ADDR, d);
    check(16'(d), 16'(TMC_CTRL_RESET));
    wr(TMC_CTRL_B_ADDR, 8'hFF);
    rd(TMC_CTRL_B_ADDR, d);
    check(16'(d), 16'h00DF);
    wr(TMC_CTRL_C_ADDR, 8'h3F);
    #1;
    check({14'h0000, force_compare_a, force_compare_b}, 16'h0000);
    rd(TMC_CTRL_C_ADDR, d);
    check(16'(d), 16'h0000);
    wr(8'h93, 8'hFF);
    rd(8'h93, d);
    check(16'(d), 16'h0000);
    rd(TMC_CTRL_A_ADDR, d);
    check(16'(d), 16'h0000);
    // Every mode: top source, update point, overflow point, capture-top flag, force strobes
    for (int m = 0; m < 16; m++) begin
      logic [3:0] mv;
      logic np;
      mv = 4'(m);
      np = (m == 0 || m == 4 || m == 12);
      @(posedge clk_sys);
      compare_a_reg <= 16'h1000 + 16'(m);
      capture_value_reg <= 16'h2000 + 16'(m);
      wr(TMC_CTRL_A_ADDR, 8'h9C | {6'b000000, mv[1:0]});
      wr(TMC_CTRL_B_ADDR, {3'b000, mv[3:2], 3'b000});
      repeat (2) @(posedge clk_sys);
      #1;
      check(16'(wave_mode), 16'(mv));
      check(top_value, exp_top(m));
      check(16'(update_point), 16'(exp_pt(m)));
      check({12'h000, com_a, com_b}, 16'h0009);
      rd(TMC_CTRL_A_ADDR, d);
      check(16'(d), 16'h0090 | 16'(mv[1:0]));
      for (int k = 0; k < 3; k++) begin
        @(posedge clk_sys);
        {counter_at_top, counter_at_bottom, counter_at_max} <= 3'b100 >> k;
        @(posedge clk_sys);
        {counter_at_top, counter_at_bottom, counter_at_max} <= 3'b000;
        #1;
        check(16'(overflow_flag_set), 16'(ovf_src(m) == k));
        check(16'(capture_flag), 16'(k == 0 && (m == 8 || m == 10 || m == 12 || m == 14)));
      end
      wr(TMC_CTRL_C_ADDR, mv[2] ? 8'h40 : 8'h80);
      #1;
      check(16'(force_compare_a), 16'(np && !mv[2]));
      check(16'(force_compare_b), 16'(np && mv[2]));
      @(posedge clk_sys);
      #1;
      check(16'(force_compare_a | force_compare_b), 16'h0000);
    end
    wr(TMC_CTRL_A_ADDR, 8'h00);
    cs_run(3'h0, 0);
    cs_run(3'h1, 2048);
    cs_run(3'h2, 256);
    cs_run(3'h3, 32);
    cs_run(3'h4, 8);
    cs_run(3'h5, 2);
    cs_run(3'h6, 3);
    cs_run(3'h7, 4);
    cap_try(8'h00, 1'b0, 99, 4);
    cap_try(8'h40, 1'b1, 99, 4);
    cap_try(8'h40, 1'b0, 99, 0);
    cap_try(8'h80, 1'b0, 99, 8);
    cap_try(8'h80, 1'b0, 2, 0);
    cap_try(8'h18, 1'b0, 99, 0);
    give_verdict();
  end

endmodule : testbench
